// >>> hdl/ssr_pkg.sv
//------------------------------------------------------------
// Contract
//------------------------------------------------------------
// Contract
// RULE1: Store-status writes six program registers plus designator into seven words, top given.
// RULE2: Store goes downward: designator, acc, ext acc, shift, index2, index1, locator.
// RULE3: After storing, store-status jumps to highest list word plus one.
// RULE4: Saved locator equals the address of the store-status instruction itself.
// RULE5: Store may take list top from first index; index ends as top minus seven.
// RULE6: Enter-status reads seven words upward from lowest: locator, index1, index2, shift, ext, acc, designator.
// RULE7: Enter-status then continues at the loaded locator plus one.
// RULE8: Enter-status accepts every normal operand address mode for its list start.
// RULE9: Word 257 decimal serves as scratch storage during both status instructions.
// RULE10: Restored designator carries the external interrupt lockout flip-flop state.
// RULE11: One memory access per step; next fetch held off until all words move.
package ssr_pkg;

   localparam logic [15:0] SCRATCH_ADDR  = 16'h0101;
   localparam logic [2:0]  STEP_LAST     = 3'h6;
   localparam logic [15:0] INDEX_BACKOFF = 16'h0007;
   localparam logic [15:0] JUMP_STEP     = 16'h0001;
   localparam int          LOCKOUT_POS   = 0;

   typedef enum logic [1:0] {
      SSR_IDLE    = 2'h0,
      SSR_SCRATCH = 2'h1,
      SSR_XFER    = 2'h3,
      SSR_FINISH  = 2'h2
   } ssr_state_type;

   typedef enum logic [2:0] {
      SSR_REG_P = 3'h0,
      SSR_REG_B = 3'h1,
      SSR_REG_C = 3'h2,
      SSR_REG_G = 3'h3,
      SSR_REG_E = 3'h4,
      SSR_REG_A = 3'h5,
      SSR_REG_D = 3'h6
   } ssr_reg_type;

   typedef struct packed {
      logic [15:0] p;
      logic [15:0] b;
      logic [15:0] c;
      logic [15:0] g;
      logic [15:0] e;
      logic [15:0] a;
      logic [15:0] d;
   } ssr_regs_type;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ssr_mem_type;

   typedef struct packed {
      logic        strobe;
      ssr_reg_type sel;
      logic [15:0] data;
   } ssr_load_type;

endpackage : ssr_pkg

// >>> hdl/ssr_order.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_order
   import ssr_pkg::*;
(
   input  wire logic         enter,
   input  wire logic [2:0]   step,
   input  wire logic [15:0]  base,
   input  wire ssr_regs_type regs,
   output ssr_reg_type       sel,
   output logic [15:0]       addr,
   output logic [15:0]       data
);

   //------------------------------------------------------------
   // Step to register and address
   //------------------------------------------------------------
   // Register picked by id
   function automatic logic [15:0] pick(input ssr_reg_type r, input ssr_regs_type v);
      case (r)
         SSR_REG_P: pick = v.p;
         SSR_REG_B: pick = v.b;
         SSR_REG_C: pick = v.c;
         SSR_REG_G: pick = v.g;
         SSR_REG_E: pick = v.e;
         SSR_REG_A: pick = v.a;
         default:   pick = v.d;
      endcase
   endfunction : pick

   // Store runs downward from designator, enter upward from locator
   always_comb begin
      if (enter) begin
         sel  = ssr_reg_type'(step);                     // RULE6
         addr = base + {13'h0000, step};                 // RULE6
      end else begin
         sel  = ssr_reg_type'(STEP_LAST - step);         // RULE2
         addr = base - {13'h0000, step};                 // RULE1
      end
      data = pick(sel, regs);
   end

endmodule : ssr_order
`default_nettype wire

// >>> hdl/ssr_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_sequencer
   import ssr_pkg::*;
(
   input  wire logic         CORE_CLK,
   input  wire logic         RST_N,
   input  wire logic         START_STORE,
   input  wire logic         START_ENTER,
   input  wire logic         USE_INDEX,
   input  wire logic [15:0]  OPERAND_ADDR,
   input  wire logic [15:0]  INSTR_ADDR,
   input  wire ssr_regs_type REGS,
   input  wire logic         MEM_ACK,
   input  wire logic [15:0]  MEM_RDATA,
   output ssr_mem_type       MEM_CMD,
   output ssr_load_type      LOAD,
   output logic              LOCKOUT,
   output logic              BUSY,
   output logic              JUMP_VALID,
   output logic [15:0]       JUMP_ADDR
);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   ssr_state_type state;
   logic [2:0]    step;
   logic [15:0]   base;
   logic          is_enter;
   logic          indexed;
   logic [15:0]   new_p;
   ssr_regs_type  snap;
   ssr_reg_type   cur_sel;
   logic [15:0]   cur_addr;
   logic [15:0]   cur_data;
   logic          acc_done;
   logic          start;
   logic          idx_start;

   assign start    = (START_STORE | START_ENTER) & (state == SSR_IDLE);
   // Index origin only for a store; enter wins when both starts meet
   assign idx_start = START_STORE & ~START_ENTER & USE_INDEX;
   assign acc_done = MEM_CMD.req & MEM_ACK;

   ssr_order u_order (
      .enter (is_enter),
      .step  (step),
      .base  (base),
      .regs  (snap),
      .sel   (cur_sel),
      .addr  (cur_addr),
      .data  (cur_data)
   );

   //------------------------------------------------------------
   // Sequence control
   //------------------------------------------------------------
   // Capture of operands and step walk
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state    <= SSR_IDLE;
         step     <= 3'h0;
         base     <= 16'h0000;
         is_enter <= 1'b0;
         indexed  <= 1'b0;
         snap     <= '0;
      end else begin
         case (state)
            SSR_IDLE: begin
               if (start) begin
                  state    <= SSR_SCRATCH;
                  step     <= 3'h0;
                  is_enter <= START_ENTER;
                  indexed  <= idx_start;
                  // List origin from any address mode, or first index
                  base     <= idx_start ? REGS.b : OPERAND_ADDR;                 // RULE5 RULE8
                  snap     <= REGS;
                  snap.p   <= INSTR_ADDR;                                       // RULE4
               end
            end
            SSR_SCRATCH: begin
               if (acc_done) begin
                  state <= SSR_XFER;
               end
            end
            SSR_XFER: begin
               if (acc_done) begin
                  if (step == STEP_LAST) begin
                     state <= SSR_FINISH;                                       // RULE1
                  end else begin
                     step <= step + 3'h1;
                  end
               end
            end
            SSR_FINISH: begin
               if (acc_done) begin
                  state <= SSR_IDLE;
               end
            end
            default: state <= SSR_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // Memory port
   //------------------------------------------------------------
   // One request held until acknowledged, then dropped a cycle
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MEM_CMD <= '0;
      end else if (acc_done) begin
         MEM_CMD.req <= 1'b0;                                                   // RULE11
      end else if (start) begin
         MEM_CMD.req   <= 1'b1;                                                 // RULE9
         MEM_CMD.we    <= 1'b1;
         MEM_CMD.addr  <= SCRATCH_ADDR;
         MEM_CMD.wdata <= idx_start ? REGS.b : OPERAND_ADDR;
      end else if (!MEM_CMD.req && state == SSR_XFER) begin
         MEM_CMD.req   <= 1'b1;
         MEM_CMD.we    <= ~is_enter;                                            // RULE1 RULE6
         MEM_CMD.addr  <= cur_addr;
         MEM_CMD.wdata <= cur_data;
      end else if (!MEM_CMD.req && state == SSR_FINISH) begin
         MEM_CMD.req   <= 1'b1;                                                 // RULE9
         MEM_CMD.we    <= 1'b0;
         MEM_CMD.addr  <= SCRATCH_ADDR;
      end
   end

   //------------------------------------------------------------
   // Register loads
   //------------------------------------------------------------
   // Load strobes from read data, index backoff at the end
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         LOAD    <= '0;
         LOCKOUT <= 1'b0;
         new_p   <= 16'h0000;
      end else begin
         LOAD.strobe <= 1'b0;
         if (acc_done && state == SSR_XFER && is_enter) begin
            LOAD.strobe <= 1'b1;                                                // RULE6
            LOAD.sel    <= cur_sel;
            LOAD.data   <= MEM_RDATA;
            if (cur_sel == SSR_REG_P) begin
               new_p <= MEM_RDATA;
            end
            if (cur_sel == SSR_REG_D) begin
               LOCKOUT <= MEM_RDATA[LOCKOUT_POS];                               // RULE10
            end
         end else if (acc_done && state == SSR_FINISH && indexed) begin
            LOAD.strobe <= 1'b1;                                                // RULE5
            LOAD.sel    <= SSR_REG_B;
            LOAD.data   <= base - INDEX_BACKOFF;
         end
      end
   end

   //------------------------------------------------------------
   // Jump and fetch hold
   //------------------------------------------------------------
   // Busy from start until the jump is issued
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         BUSY       <= 1'b0;
         JUMP_VALID <= 1'b0;
         JUMP_ADDR  <= 16'h0000;
      end else begin
         JUMP_VALID <= 1'b0;
         if (start) begin
            BUSY <= 1'b1;                                                       // RULE11
         end else if (acc_done && state == SSR_FINISH) begin
            BUSY       <= 1'b0;
            JUMP_VALID <= 1'b1;
            // Store jumps past its list top, enter past the new locator
            JUMP_ADDR  <= is_enter ? new_p + JUMP_STEP : MEM_RDATA + JUMP_STEP; // RULE3 RULE7
         end
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   sequence seq_start;
      state == SSR_IDLE && (START_STORE || START_ENTER);
   endsequence

   sequence seq_scratch;
      MEM_CMD.req && MEM_CMD.we && MEM_CMD.addr == SCRATCH_ADDR;
   endsequence

   sequence seq_last_store;
      acc_done && state == SSR_FINISH && indexed;
   endsequence

   scratch_first_a: assert property (seq_start |=> seq_scratch)                 // RULE9
      else $error("scratch word not written first");
   store_down_a: assert property (state == SSR_XFER && MEM_CMD.req && !is_enter  // RULE2
      |-> MEM_CMD.we && MEM_CMD.addr == base - {13'h0000, step})
      else $error("store address not descending");
   enter_up_a: assert property (state == SSR_XFER && MEM_CMD.req && is_enter    // RULE6
      |-> !MEM_CMD.we && MEM_CMD.addr == base + {13'h0000, step})
      else $error("enter address not ascending");
   store_jump_a: assert property (JUMP_VALID && !is_enter                        // RULE3
      |-> JUMP_ADDR == base + JUMP_STEP)
      else $error("store jump target wrong");
   enter_jump_a: assert property (JUMP_VALID && is_enter                         // RULE7
      |-> JUMP_ADDR == new_p + JUMP_STEP)
      else $error("enter jump target wrong");
   p_saved_a: assert property (state == SSR_XFER && MEM_CMD.req && !is_enter     // RULE4
      && step == STEP_LAST |-> MEM_CMD.wdata == snap.p)
      else $error("saved locator wrong");
   index_back_a: assert property (seq_last_store                                 // RULE5
      |=> LOAD.strobe && LOAD.sel == SSR_REG_B && LOAD.data == base - INDEX_BACKOFF)
      else $error("index not backed off by seven");
   busy_hold_a: assert property (seq_start |=> BUSY throughout (state != SSR_IDLE)) // RULE11
      else $error("fetch not held during sequence");
   single_access_a: assert property (acc_done |=> !MEM_CMD.req)                 // RULE11
      else $error("access not closed after ack");
   lockout_load_a: assert property (LOAD.strobe && LOAD.sel == SSR_REG_D         // RULE10
      |-> LOCKOUT == LOAD.data[LOCKOUT_POS])
      else $error("lockout not restored");
   seven_steps_a: assert property (state == SSR_XFER && acc_done && step == STEP_LAST // RULE1
      |=> state == SSR_FINISH)
      else $error("list not seven words");

endmodule : ssr_sequencer
`default_nettype wire

// >>> test/ssr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_mem_model
   import ssr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire ssr_mem_type cmd,
   input  wire logic [3:0]  lat,
   output logic             ack,
   output logic [15:0]      rdata
);
   //------------------------------------------------------------
   // Core memory behind the sequencer
   //------------------------------------------------------------
   logic [15:0] mem [0:65535];
   logic [3:0]  wait_cnt;
   int          n_ack;

   initial n_ack = 0;

   // Acknowledge after lat cycles; read data scrambles once released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack      <= 1'b0;
         wait_cnt <= 4'h0;
         rdata    <= 16'h0000;
      end else if (ack) begin
         ack      <= 1'b0; // One access served at a time
         wait_cnt <= 4'h0;
         rdata    <= ~rdata;
      end else if (cmd.req && wait_cnt >= lat) begin
         ack   <= 1'b1;
         rdata <= mem[cmd.addr]; // Scratch word returns what was written
      end else begin
         wait_cnt <= cmd.req ? wait_cnt + 4'h1 : 4'h0;
         rdata    <= ~rdata;
      end
   end

   // Write on the accepting edge, count accesses
   always @(posedge clk) begin
      if (rst_n && ack && cmd.req) begin
         n_ack++;
         if (cmd.we) mem[cmd.addr] <= cmd.wdata;
      end
   end
endmodule : ssr_mem_model
`default_nettype wire

// >>> test/status_save_restore_test.sv
`timescale 1ns/1ps
`default_nettype none
module status_save_restore_test
   import ssr_pkg::*;
;
   //------------------------------------------------------------
   // Signals, instances, clock
   //------------------------------------------------------------
   typedef struct packed {logic enter; logic idx; logic [15:0] base; logic [3:0] lat;
                          logic [15:0] jump;} ssr_row_type;
   logic          core_clk, rst_n, start_store, start_enter, use_index, mem_ack, lockout;
   logic          busy, jump_valid;
   logic [15:0]   operand_addr, instr_addr, mem_rdata, jump_addr;
   logic [3:0]    lat;
   ssr_regs_type  regs;
   ssr_mem_type   mem_cmd;
   ssr_load_type  load;
   ssr_load_type  loads [$];
   int            n_mismatch, checks;
   ssr_row_type   rows [5] = '{'{0, 0, 16'h5008, 0, 16'h5009}, '{0, 1, 16'h2047, 2, 16'h2048},
                               '{1, 0, 16'h5002, 1, 16'h1103}, '{1, 0, 16'hfff0, 3, 16'h1104},
                               '{0, 0, 16'h7fff, 1, 16'h8000}};

   ssr_sequencer i_ssr_sequencer (.CORE_CLK(core_clk), .RST_N(rst_n), .START_STORE(start_store),
      .START_ENTER(start_enter), .USE_INDEX(use_index), .OPERAND_ADDR(operand_addr),
      .INSTR_ADDR(instr_addr), .REGS(regs), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
      .MEM_CMD(mem_cmd), .LOAD(load), .LOCKOUT(lockout), .BUSY(busy),
      .JUMP_VALID(jump_valid), .JUMP_ADDR(jump_addr));
   ssr_mem_model i_ssr_mem_model (.clk(core_clk), .rst_n(rst_n), .cmd(mem_cmd), .lat(lat),
      .ack(mem_ack), .rdata(mem_rdata));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Register value k of row r
   function automatic logic [15:0] rv(input int r, input int k);
      return 16'(16'h1100 * (k + 1) + r);
   endfunction : rv

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   // One instruction; a poke raises a start while busy, which must be ignored
   task automatic run_op(input ssr_row_type w, input int r, input bit poke);
      logic [15:0] vals [7];
      int          n0;
      int          bad;
      bad = 0;
      lat = w.lat;
      vals[0] = 16'(16'h6000 + r);
      vals[1] = w.idx ? w.base : rv(r, 1);
      for (int k = 2; k < 7; k++) vals[k] = rv(r, k);
      if (w.enter) for (int k = 0; k < 7; k++) i_ssr_mem_model.mem[16'(w.base + k)] = rv(r, k);
      use_index = w.idx;
      operand_addr = w.idx ? 16'h3333 : w.base;
      instr_addr = vals[0];
      regs = '{p:16'h0bad, b:vals[1], c:vals[2], g:vals[3], e:vals[4], a:vals[5], d:vals[6]};
      start_store = ~w.enter;
      start_enter = w.enter;
      n0 = i_ssr_mem_model.n_ack;
      loads.delete();
      @(posedge core_clk);
      #1;
      start_store = 1'b0;
      for (int cyc = 0; cyc < 300 && jump_valid !== 1'b1; cyc++) begin
         if (busy !== 1'b1) bad++;
         if (load.strobe === 1'b1) loads.push_back(load);
         start_enter = poke && cyc == 4; // Also ends the start of an enter
         @(posedge core_clk);
         #1;
      end
      if (load.strobe === 1'b1) loads.push_back(load);
      chk("busy gaps", 0, bad);
      chk("access count", 9, i_ssr_mem_model.n_ack - n0);
      chk("scratch word", w.base, i_ssr_mem_model.mem[16'h0101]);
      if (!w.enter) begin
         for (int k = 0; k < 7; k++)
            chk("stored word", vals[6 - k], i_ssr_mem_model.mem[16'(w.base - k)]);
         chk("store jump", w.jump, jump_addr);
         chk("reload count", w.idx, loads.size());
         if (w.idx && loads.size() > 0)
            chk("index reload", {SSR_REG_B, 16'(w.base - 7)}, {loads[0].sel, loads[0].data});
      end else begin
         chk("load count", 7, loads.size());
         for (int k = 0; k < 7 && k < loads.size(); k++)
            chk("loaded word", {3'(k), rv(r, k)}, {loads[k].sel, loads[k].data});
         chk("enter jump", w.jump, jump_addr);
         chk("lockout", rv(r, 6) & 16'h0001, lockout);
      end
      $display("Test %0d done", r);
   endtask : run_op

   //------------------------------------------------------------
   // Sequence and watchdog
   //------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      checks = 0;
      {rst_n, start_store, start_enter, use_index, lat} = '0;
      {operand_addr, instr_addr} = '0;
      regs = '0;
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      @(posedge core_clk);
      #1;
      chk("idle outputs", 0, {mem_cmd.req, load.strobe, lockout, busy, jump_valid});
      // Table rows run back to back, each after the first started in the jump cycle of the one before
      for (int r = 0; r < 5; r++) run_op(rows[r], r, 1'b0);
      run_op('{0, 1, 16'h4010, 1, 16'h4011}, 5, 1'b1);
      // Reset in mid-sequence returns every output to idle
      start_store = 1'b1;
      @(posedge core_clk);
      #1;
      start_store = 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      rst_n = 1'b0;
      #1;
      chk("reset outputs", 0, {mem_cmd.req, load.strobe, lockout, busy, jump_valid});
      @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      @(posedge core_clk);
      #1;
      chk("restart idle", 0, {mem_cmd.req, load.strobe, lockout, busy, jump_valid});
      run_op('{0, 0, 16'h5008, 2, 16'h5009}, 6, 1'b0);
      report_and_stop();
   end

   initial begin
      repeat (2000) @(posedge core_clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule : status_save_restore_test
`default_nettype wire
